//--- pkg/periph_irq_defines.svh
// Register offsets, field positions and reset values of the bank decode and interrupt steering block.
`ifndef PERIPH_IRQ_DEFINES_SVH
`define PERIPH_IRQ_DEFINES_SVH

`define PB_OFF_STATUS 8'h00
`define PB_OFF_MASK 8'h04
`define PB_OFF_PRIO 8'h08
`define PB_OFF_VECTOR 8'h0C
`define PB_OFF_BANK 8'h10

`define PB_SRC_HSYNC 0
`define PB_SRC_VSYNC 1
`define PB_SRC_TIMER0 2
`define PB_SRC_TIMER1 3
`define PB_NSRC 4
`define PB_PRIO_W 2

`define PB_LINE_HSYNC 0
`define PB_LINE_VSYNC 1
`define PB_LINE_TIMER 2

`define PB_CRIT_BANK 2'h3

`define PB_STATUS_RST 4'h0
`define PB_MASK_RST 4'h0
`define PB_PRIO_RST 8'h00

`endif

//--- pkg/periph_irq_pkg.sv
// Types shared by the bank decode and interrupt steering block.
package periph_irq_pkg;

  typedef struct packed {
    logic timer1;
    logic timer0;
    logic vsync;
    logic hsync;
  } irq_src_t;

  typedef struct packed {
    logic [1:0] bank;
    logic [2:0] addr;
    logic strobe;
    logic rd;
  } ext_req_t;

endpackage

//--- src/bank_decode.sv
// Banked external register select decoder for the core's register port.
`timescale 1ns/1ns
`default_nettype none
`include "periph_irq_defines.svh"

module bank_decode #(
  parameter int BANKS = 4,
  parameter int REGS = 8
) (
  input wire logic mclk, // System clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire periph_irq_pkg::ext_req_t ext, // Core register port request.
  output logic [BANKS*REGS-1:0] sel_r, // One-hot register select.
  output logic crit_r, // Access falls in the critical bank.
  output logic [4:0] last_idx_r // Index of the last selected register.
);

  function automatic logic [4:0] reg_index(input logic [1:0] bank, input logic [2:0] addr);
    return {bank, addr};
  endfunction

  logic [4:0] idx_now;

  assign idx_now = reg_index(ext.bank, ext.addr);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sel_r <= '0;
    end else begin
      sel_r <= '0;
      if (ext.strobe) begin
        sel_r[idx_now] <= 1'b1;
      end
    end
  end

  // Bank 3 gathers the speed critical registers, so it gets its own qualified flag.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      crit_r <= 1'b0;
    end else begin
      crit_r <= ext.strobe && (ext.bank == `PB_CRIT_BANK);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      last_idx_r <= 5'h00;
    end else if (ext.strobe) begin
      last_idx_r <= reg_index(ext.bank, ext.addr);
    end
  end

  property p_sel_hit;
    @(posedge mclk) disable iff (reset)
    ext.strobe |=> $onehot(sel_r) && sel_r[$past(idx_now)];
  endproperty
  a_sel_hit: assert property (p_sel_hit) else $error("select does not match bank and address");

  property p_sel_idle;
    @(posedge mclk) disable iff (reset)
    !ext.strobe |=> (sel_r == '0);
  endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("select active without strobe");

  property p_crit;
    @(posedge mclk) disable iff (reset)
    ext.strobe && (ext.bank == 2'h3) |=> crit_r && (sel_r[31:24] != 8'h00);
  endproperty
  a_crit: assert property (p_crit) else $error("bank 3 access not flagged critical");

endmodule // bank_decode
`default_nettype wire

//--- src/irq_steer.sv
// Steers four interrupt sources onto three core lines and keeps the timer vector bit.
`timescale 1ns/1ns
`default_nettype none
`include "periph_irq_defines.svh"

module irq_steer (
  input wire logic mclk, // System clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic [3:0] eff, // Pending and unmasked sources.
  input wire logic [7:0] prio, // Two-bit priority per source.
  input wire logic [1:0] t_evt, // Timer event pulses.
  output logic [2:0] core_irq_r, // Core interrupt lines.
  output logic vec_r // Timer vector: 0 timer0, 1 timer1.
);

  function automatic logic [1:0] prio_of(input logic [7:0] p, input int s);
    return p[2*s +: 2];
  endfunction

  logic [1:0] pr_h;
  logic [1:0] pr_v;
  logic [1:0] pr_t0;
  logic [1:0] pr_t1;
  logic [2:0] req;
  logic [1:0] gp [3];
  logic [2:0] win;

  assign pr_h = prio_of(prio, `PB_SRC_HSYNC);
  assign pr_v = prio_of(prio, `PB_SRC_VSYNC);
  assign pr_t0 = prio_of(prio, `PB_SRC_TIMER0);
  assign pr_t1 = prio_of(prio, `PB_SRC_TIMER1);

  // Timers share one line as a plain OR; the group takes the priority of its highest pending timer.
  always_comb begin
    req[`PB_LINE_HSYNC] = eff[`PB_SRC_HSYNC];
    req[`PB_LINE_VSYNC] = eff[`PB_SRC_VSYNC];
    req[`PB_LINE_TIMER] = eff[`PB_SRC_TIMER0] | eff[`PB_SRC_TIMER1];
    gp[0] = pr_h;
    gp[1] = pr_v;
    if (eff[`PB_SRC_TIMER0] && eff[`PB_SRC_TIMER1]) begin
      gp[2] = (pr_t1 > pr_t0) ? pr_t1 : pr_t0;
    end else if (eff[`PB_SRC_TIMER1]) begin
      gp[2] = pr_t1;
    end else begin
      gp[2] = pr_t0;
    end
  end

  // A pending line is held off only while another pending line has strictly higher priority.
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      win[k] = req[k];
      for (int j = 0; j < 3; j++) begin
        if (j != k && req[j] && (gp[j] > gp[k])) begin
          win[k] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      core_irq_r <= 3'h0;
    end else begin
      core_irq_r <= win;
    end
  end

  // On a tie of both timers in one cycle the higher priority timer names the vector.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      vec_r <= 1'b0;
    end else begin
      case (t_evt)
        2'b01: vec_r <= 1'b0;
        2'b10: vec_r <= 1'b1;
        2'b11: vec_r <= (pr_t1 > pr_t0);
        default: vec_r <= vec_r;
      endcase
    end
  end

  property p_timer_or;
    @(posedge mclk) disable iff (reset)
    !(eff[2] | eff[3]) |=> !core_irq_r[2];
  endproperty
  a_timer_or: assert property (p_timer_or) else $error("timer line raised with no timer pending");

  property p_timer_line;
    @(posedge mclk) disable iff (reset)
    (eff[2] | eff[3]) && !eff[0] && !eff[1] |=> core_irq_r[2];
  endproperty
  a_timer_line: assert property (p_timer_line) else $error("lone timer request not on shared line");

  property p_dedicated;
    @(posedge mclk) disable iff (reset)
    eff[0] && !eff[1] && !eff[2] && !eff[3] |=> core_irq_r == 3'h1;
  endproperty
  a_dedicated: assert property (p_dedicated) else $error("hsync not on its own line");

  property p_prio;
    @(posedge mclk) disable iff (reset)
    eff[0] && eff[1] && !eff[2] && !eff[3] && (pr_h > pr_v) |=> core_irq_r[0] && !core_irq_r[1];
  endproperty
  a_prio: assert property (p_prio) else $error("priority order not kept");

  sequence s_t1_evt;
    t_evt == 2'b10;
  endsequence

  sequence s_quiet_2;
    (t_evt == 2'b00) [*2];
  endsequence

  property p_vec1;
    @(posedge mclk) disable iff (reset)
    s_t1_evt ##1 s_quiet_2 |-> vec_r;
  endproperty
  a_vec1: assert property (p_vec1) else $error("vector does not name timer1");

  property p_vec0;
    @(posedge mclk) disable iff (reset)
    t_evt == 2'b01 |=> !vec_r;
  endproperty
  a_vec0: assert property (p_vec0) else $error("vector does not name timer0");

endmodule // irq_steer
`default_nettype wire

//--- src/periph_irq_top.sv
// Top of the banked register decode and interrupt steering block with its APB register file.
`timescale 1ns/1ns
`default_nettype none
`include "periph_irq_defines.svh"

// Summary of operation
// - Three register address lines pick one of eight registers within a bank.
// - Two user bits name the bank, giving four banks of eight registers.
// - The most speed critical registers sit together in bank 3.
// - Four interrupt sources reach the core over only three interrupt lines.
// - Both timer requests are ORed onto one shared core interrupt line.
// - One register bit is the vector naming which timer requested.
// - A timer interrupt updates the vector bit to name that timer.
// - Each source has a software priority and mask in registers.
module periph_irq_top (
  input wire logic mclk, // System clock, 20 MHz.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic hsync_pin, // Horizontal sync pin.
  input wire logic vsync_pin, // Vertical sync pin.
  input wire logic [1:0] timer_pair_irq, // Timer request pulses, same clock.
  input wire periph_irq_pkg::ext_req_t ext, // Core external register port.
  output logic [31:0] reg_sel, // One-hot external register select.
  output logic crit_sel, // Access is in the critical bank.
  output logic [2:0] core_irq, // Core interrupt lines.
  output logic timer_vec, // Timer vector bit.
  output logic irq // Summary interrupt, level.
);

  logic [2:0] hs_sync_r;
  logic [2:0] vs_sync_r;
  logic [1:0] lvl_r;
  logic h_evt;
  logic v_evt;
  periph_irq_pkg::irq_src_t src_evt;
  logic [3:0] status_r;
  logic [3:0] status_nxt;
  logic [3:0] mask_r;
  logic [7:0] prio_r;
  logic [3:0] eff;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic [2:0] core_irq_w;
  logic vec_w;
  logic [31:0] sel_w;
  logic crit_w;
  logic [4:0] last_idx_w;
  logic done;
  logic prep;

  function automatic logic addr_ok(input logic [7:0] a);
    return (a == `PB_OFF_STATUS) || (a == `PB_OFF_MASK) || (a == `PB_OFF_PRIO) ||
           (a == `PB_OFF_VECTOR) || (a == `PB_OFF_BANK);
  endfunction

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [3:0] st, input logic [3:0] mk,
                                         input logic [7:0] pr, input logic vc, input logic [2:0] ci,
                                         input logic [4:0] li, input logic cr);
    case (a)
      `PB_OFF_STATUS: return {28'h000_0000, st};
      `PB_OFF_MASK: return {28'h000_0000, mk};
      `PB_OFF_PRIO: return {24'h00_0000, pr};
      `PB_OFF_VECTOR: return {28'h000_0000, ci, vc};
      `PB_OFF_BANK: return {26'h000_0000, cr, li};
      default: return 32'h0000_0000;
    endcase
  endfunction

  // Sync pins pass three flops; a rising edge counts once the second and third agree.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hs_sync_r <= 3'h0;
      vs_sync_r <= 3'h0;
    end else begin
      hs_sync_r <= {hs_sync_r[1:0], hsync_pin};
      vs_sync_r <= {vs_sync_r[1:0], vsync_pin};
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lvl_r <= 2'h0;
    end else begin
      if (hs_sync_r[1] == hs_sync_r[2]) begin
        lvl_r[0] <= hs_sync_r[1];
      end
      if (vs_sync_r[1] == vs_sync_r[2]) begin
        lvl_r[1] <= vs_sync_r[1];
      end
    end
  end

  assign h_evt = (hs_sync_r[1] == hs_sync_r[2]) && hs_sync_r[1] && !lvl_r[0];
  assign v_evt = (vs_sync_r[1] == vs_sync_r[2]) && vs_sync_r[1] && !lvl_r[1];

  always_comb begin
    src_evt.hsync = h_evt;
    src_evt.vsync = v_evt;
    src_evt.timer0 = timer_pair_irq[0];
    src_evt.timer1 = timer_pair_irq[1];
  end

  // One wait state: data is sampled in the first access cycle, the transfer ends on the next edge.
  assign prep = psel && penable && !pready_r;
  assign done = psel && penable && pready_r;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= prep;
      if (prep) begin
        pslverr_r <= !addr_ok(paddr);
        prdata_r <= pwrite ? 32'h0000_0000 :
                    rd_mux(paddr, status_r, mask_r, prio_r, vec_w, core_irq_w, last_idx_w, crit_w);
      end
    end
  end

  // Only bits already returned in the read data are cleared, so an event landing between sampling
  // and completion survives; a new event also wins over the clear in the same cycle.
  always_comb begin
    status_nxt = status_r;
    if (done && !pwrite && (paddr == `PB_OFF_STATUS)) begin
      status_nxt = status_r & ~prdata_r[3:0];
    end
    status_nxt = status_nxt | src_evt;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      status_r <= `PB_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mask_r <= `PB_MASK_RST;
      prio_r <= `PB_PRIO_RST;
    end else if (done && pwrite) begin
      if (paddr == `PB_OFF_MASK) begin
        mask_r <= pwdata[3:0];
      end
      if (paddr == `PB_OFF_PRIO) begin
        prio_r <= pwdata[7:0];
      end
    end
  end

  assign eff = status_r & mask_r;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |eff;
    end
  end

  bank_decode #(
    .BANKS(4),
    .REGS(8)
  ) u_decode (
    .mclk(mclk),
    .reset(reset),
    .ext(ext),
    .sel_r(sel_w),
    .crit_r(crit_w),
    .last_idx_r(last_idx_w)
  );

  irq_steer u_steer (
    .mclk(mclk),
    .reset(reset),
    .eff(eff),
    .prio(prio_r),
    .t_evt(timer_pair_irq),
    .core_irq_r(core_irq_w),
    .vec_r(vec_w)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign reg_sel = sel_w;
  assign crit_sel = crit_w;
  assign core_irq = core_irq_w;
  assign timer_vec = vec_w;
  assign irq = irq_r;

  sequence s_access_wait;
    psel && penable && !pready_r;
  endsequence

  property p_apb_wait;
    @(posedge mclk) disable iff (reset)
    s_access_wait |=> pready_r;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("ready not raised after one wait cycle");

  property p_slverr;
    @(posedge mclk) disable iff (reset)
    (s_access_wait and !addr_ok(paddr)) |=> pslverr_r && pready_r;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped address not flagged");

  property p_mask_write;
    @(posedge mclk) disable iff (reset)
    done && pwrite && (paddr == 8'h04) |=> mask_r == $past(pwdata[3:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

  property p_masked_quiet;
    @(posedge mclk) disable iff (reset)
    (mask_r == 4'h0) [*2] |=> !irq_r && (core_irq_w == 3'h0);
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked source raised interrupt");

  property p_set_wins;
    @(posedge mclk) disable iff (reset)
    src_evt.timer0 |=> status_r[2];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("timer0 event lost");

  property p_irq_level;
    @(posedge mclk) disable iff (reset)
    (|eff) |=> irq_r;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt output not raised");

  // A read of the status word must drop a returned timer0 bit unless a fresh timer0 event lands in the same cycle.
  property p_read_clear;
    @(posedge mclk) disable iff (reset)
    done && !pwrite && (paddr == `PB_OFF_STATUS) && prdata_r[2] && !src_evt.timer0 |=> !status_r[2];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read did not clear timer0");

  property p_timer_masked;
    @(posedge mclk) disable iff (reset)
    !mask_r[2] && !mask_r[3] |=> !core_irq_w[2];
  endproperty
  a_timer_masked: assert property (p_timer_masked) else $error("masked timers reached shared line");

endmodule // periph_irq_top
`default_nettype wire

//--- sim/core_port_model.sv
// Behavioural model of the processor core's register port and interrupt entry.
`timescale 1ns/1ns
`default_nettype none

module core_port_model (
  input wire logic mclk, // System clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic go, // Start one register access.
  input wire logic [1:0] bank_in, // Bank wanted.
  input wire logic [2:0] idx_in, // Register index wanted.
  input wire logic [2:0] core_irq, // Interrupt lines from the block.
  input wire logic timer_vec, // Timer vector bit.
  output periph_irq_pkg::ext_req_t ext_r, // Register port drive.
  output logic [1:0] handler_r // Last service routine entered.
);
  logic step_r;
  logic [2:0] seen_r;

  // An idle index is inverted every cycle so that a stale value can never pass for a real access.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ext_r <= '0;
      step_r <= 1'b0;
    end else if (go) begin
      ext_r.bank <= bank_in;
      ext_r.strobe <= 1'b0;
      step_r <= 1'b1;
    end else if (step_r) begin
      ext_r.addr <= idx_in;
      ext_r.strobe <= 1'b1;
      step_r <= 1'b0;
    end else begin
      ext_r.addr <= ~ext_r.addr;
      ext_r.strobe <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      seen_r <= 3'h0;
      handler_r <= 2'h0;
    end else begin
      seen_r <= core_irq;
      if (core_irq[2] && !seen_r[2]) begin
        handler_r <= {1'b1, timer_vec};
      end else if (core_irq[1] && !seen_r[1]) begin
        handler_r <= 2'h1;
      end else if (core_irq[0] && !seen_r[0]) begin
        handler_r <= 2'h0;
      end
    end
  end
endmodule // core_port_model

`default_nettype wire

//--- sim/peripheral_bank_decode_and_irq_steering_test.sv
// Self-checking testbench of the bank decode and interrupt steering block.
`timescale 1ns/1ns
`default_nettype none
`include "periph_irq_defines.svh"

module peripheral_bank_decode_and_irq_steering_test;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr, err, hsync_pin, vsync_pin;
  logic crit_sel, timer_vec, irq, go;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata, reg_sel, r;
  logic [1:0] timer_pair_irq, bank, handler;
  logic [2:0] idx, core_irq;
  periph_irq_pkg::ext_req_t ext;
  int num_errors, num_checks, cycles, seed, i;

  periph_irq_top periph_irq_top_i (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsync_pin(hsync_pin), .vsync_pin(vsync_pin), .timer_pair_irq(timer_pair_irq), .ext(ext),
    .reg_sel(reg_sel), .crit_sel(crit_sel), .core_irq(core_irq), .timer_vec(timer_vec), .irq(irq));
  core_port_model core_port_model_i (.mclk(mclk), .reset(reset), .go(go), .bank_in(bank), .idx_in(idx),
    .core_irq(core_irq), .timer_vec(timer_vec), .ext_r(ext), .handler_r(handler));

  // Larger priority wins; the timer group takes the higher of its pending timers.
  function automatic logic [2:0] exp_lines(input logic [3:0] eff, input logic [7:0] pr);
    logic [1:0] lp [3];
    logic [2:0] pend;
    logic [2:0] res;
    pend = {eff[3] | eff[2], eff[1], eff[0]};
    lp[0] = pr[1:0];
    lp[1] = pr[3:2];
    lp[2] = (eff[3] && (!eff[2] || pr[7:6] > pr[5:4])) ? pr[7:6] : pr[5:4];
    for (int k = 0; k < 3; k++) begin
      res[k] = pend[k];
      for (int j = 0; j < 3; j++) begin
        if (pend[j] && lp[j] > lp[k]) res[k] = 1'b0;
      end
    end
    return res;
  endfunction

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk("pready", 32'h0000_0001, 32'h0000_0000);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rdata);
  endtask

  task automatic access(input logic [1:0] b, input logic [2:0] x);
    @(posedge mclk);
    bank <= b;
    idx <= x;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("reg_sel", 32'h0000_0001 << {b, x}, reg_sel);
    chk("crit_sel", 32'(b == `PB_CRIT_BANK), 32'(crit_sel));
  endtask

  task automatic tpulse(input logic [1:0] v);
    @(posedge mclk);
    timer_pair_irq <= v;
    @(posedge mclk);
    timer_pair_irq <= 2'h0;
    @(posedge mclk);
    #1;
  endtask

  task automatic sync_evt(input logic vs);
    @(posedge mclk);
    if (vs) vsync_pin <= 1'b1;
    else hsync_pin <= 1'b1;
    repeat (8) @(posedge mclk);
    vsync_pin <= 1'b0;
    hsync_pin <= 1'b0;
    #1;
  endtask

  task automatic lines(input logic [2:0] exp, input logic [1:0] hnd);
    chk("core_irq", 32'(exp), 32'(core_irq));
    @(posedge mclk);
    #1;
    chk("handler", 32'(hnd), 32'(handler));
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    {reset, psel, penable, pwrite, hsync_pin, vsync_pin, go} = 7'h7F & 7'h40;
    {paddr, pwdata, timer_pair_irq, bank, idx} = '0;
    seed = 59;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    rd_chk(`PB_OFF_MASK, 32'h0000_0000, "mask reset");
    rd_chk(`PB_OFF_PRIO, 32'h0000_0000, "prio reset");
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, 32'(err));
    chk("unmapped data", 32'h0000_0000, rdata);
    access(2'h3, 3'h7);
    access(2'h0, 3'h0);
    for (i = 0; i < 12; i++) begin
      r = $random(seed);
      access(r[1:0], r[4:2]);
    end
    access(2'h3, 3'h5);
    rd_chk(`PB_OFF_BANK, 32'h0000_001D, "bank reg");
    apb(1'b1, `PB_OFF_MASK, 32'h0000_000F);
    tpulse(2'h1);
    chk("irq", 32'h0000_0001, 32'(irq));
    chk("vector t0", 32'h0000_0000, 32'(timer_vec));
    lines(3'h4, 2'h2);
    rd_chk(`PB_OFF_VECTOR, 32'h0000_0008, "vector reg");
    rd_chk(`PB_OFF_STATUS, 32'h0000_0004, "status t0");
    repeat (2) @(posedge mclk);
    #1;
    chk("core_irq cleared", 32'h0000_0000, 32'(core_irq));
    tpulse(2'h2);
    chk("vector t1", 32'h0000_0001, 32'(timer_vec));
    lines(3'h4, 2'h3);
    rd_chk(`PB_OFF_STATUS, 32'h0000_0008, "status t1");
    apb(1'b1, `PB_OFF_MASK, 32'h0000_0000);
    tpulse(2'h2);
    chk("masked line", 32'h0000_0000, {28'h0, core_irq, irq});
    rd_chk(`PB_OFF_STATUS, 32'h0000_0008, "status masked");
    apb(1'b1, `PB_OFF_MASK, 32'h0000_000F);
    sync_evt(1'b0);
    lines(3'h1, 2'h0);
    sync_evt(1'b1);
    lines(3'h3, 2'h1);
    tpulse(2'h1);
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      apb(1'b1, `PB_OFF_PRIO, {24'h0, r[7:0]});
      apb(1'b1, `PB_OFF_MASK, {28'h0, r[11:8]});
      @(posedge mclk);
      #1;
      chk("prio lines", 32'(exp_lines(r[11:8] & 4'h7, r[7:0])), 32'(core_irq));
      chk("irq summary", 32'(|(r[11:8] & 4'h7)), 32'(irq));
    end
    rd_chk(`PB_OFF_PRIO, {24'h0, r[7:0]}, "prio readback");
    // Both timers in one cycle: the vector goes to the timer of higher priority.
    apb(1'b1, `PB_OFF_PRIO, 32'h0000_0040);
    tpulse(2'h3);
    chk("vector tie t1", 32'h0000_0001, 32'(timer_vec));
    apb(1'b1, `PB_OFF_PRIO, 32'h0000_0010);
    tpulse(2'h3);
    chk("vector tie t0", 32'h0000_0000, 32'(timer_vec));
    end_of_test();
  end
endmodule // peripheral_bank_decode_and_irq_steering_test

`default_nettype wire
